// file: hdl/hbp_bridge_ctrl.sv
// Operation
// R1: Motor supply below under level for deglitch time turns all outputs off; auto resume.
// R2: Motor supply above over level for deglitch time turns all outputs off; auto resume.
// R3: One configuration bit picks which of two over-voltage levels applies.
// R4: Logic supply below power-on level holds logic, pump and drivers off.
// R5: Power-on resets logic, flag low; read with clear-on-read or clear command sets it.
// R6: Enable low resets logic, disables pump, floats all outputs, sleep.
// R7: Host waits the wake time after enable rises before expecting normal outputs.
// R8: That wake wait lasts up to 150 microseconds.
// R9: Direct mode: high bit only drives high, low only drives low, none floats.
// R10: Both side bits set floats the bridge until one is cleared.
// R11: Eight generators, each with 2-bit code selecting 80, 100, 200, 2000 Hz.
// R12: Duty equals 8-bit value over 255; 0 always off, 255 always on.
// R13: Each bridge has a 3-bit field choosing its generator independently.
// R14: PWM-select set switches the bridge from its mapped generator, not direct bits.
// R15: In PWM mode only the enabled FET switches with the generator waveform.
// R16: Per-bridge freewheel bit picks active or passive freewheeling in PWM mode.
// R17: Active freewheel: driving FET off, cross gap, then opposite FET on.
// R18: Cross gap is 28 us on slow slew and 7 us on fast slew.
// R19: Freewheel bit is ignored for bridges in direct mode.
// R20: Each generator has a stop bit; set halts it with output off.
// R21: Frequency codes 00, 01, 10, 11 select 80, 100, 200, 2000 Hz.
// R22: Passive freewheel keeps the opposite FET off during the PWM off phase.
`include "hbp_params.svh"
module hbp_bridge_ctrl #(
  parameter int P_STEP0 = `HBP_STEP_CYC(`HBP_FREQ0_HZ),
  parameter int P_STEP1 = `HBP_STEP_CYC(`HBP_FREQ1_HZ),
  parameter int P_STEP2 = `HBP_STEP_CYC(`HBP_FREQ2_HZ),
  parameter int P_STEP3 = `HBP_STEP_CYC(`HBP_FREQ3_HZ)
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic en,
  input wire hbp_pkg::hbp_supply_t supply,
  input wire logic overvolt_level_sel,
  input wire logic clear_on_read_enable,
  input wire logic status_read,
  input wire logic fault_clear_cmd,
  input wire hbp_pkg::hbp_bridge_cfg_t [11:0] bridge_cfg,
  input wire hbp_pkg::hbp_gen_cfg_t [7:0] gen_cfg,
  output hbp_pkg::hbp_gate_t [11:0] gate_drive,
  output logic charge_pump_en,
  output logic power_up_flag_n,
  output logic uv_fault,
  output logic ov_fault
);
  import hbp_pkg::*;

  localparam int DEG_CYC = `HBP_DEGLITCH_CYC;
  localparam logic [10:0] DEG_LAST = 11'(`HBP_DEGLITCH_CYC - 1);
  localparam logic [11:0] DEAD_SLOW = 12'(`HBP_DEAD_SLOW_CYC);
  localparam logic [11:0] DEAD_FAST = 12'(`HBP_DEAD_FAST_CYC);

  hbp_top_st_t r;
  hbp_top_st_t nxt;
  logic [`HBP_NUM_GENS-1:0] gen_out;
  logic ov_raw;
  logic drive_ok;
  // Generator picked by bridge 4, for the mapping check
  logic map4_on;

  // ----------------------------------------
  // PWM generators
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `HBP_NUM_GENS; g++) begin : gen_pwm
      hbp_pwm_gen #(
        .STEP0(13'(P_STEP0)),
        .STEP1(13'(P_STEP1)),
        .STEP2(13'(P_STEP2)),
        .STEP3(13'(P_STEP3))
      ) u_gen (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ce(ce),
        .run(r.en_sync && r.mode != HBP_SLEEP && !gen_cfg[g].gen_stop), // [R20] [R6]
        .cfg(gen_cfg[g]),
        .pwm_on(gen_out[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    hbp_bridge_cfg_t c;
    logic both;
    logic on_p;
    logic tgt_hs;
    logic tgt_ls;
    logic blk_hs;
    logic blk_ls;
    c = '0;
    both = 1'b0;
    on_p = 1'b0;
    tgt_hs = 1'b0;
    tgt_ls = 1'b0;
    blk_hs = 1'b0;
    blk_ls = 1'b0;
    nxt = r;
    nxt.en_meta = en;
    nxt.en_sync = r.en_meta;
    nxt.sup_meta = supply;
    nxt.sup_sync = r.sup_meta;

    ov_raw = overvolt_level_sel ? r.sup_sync.vm_over_level_hi : r.sup_sync.vm_over_level_lo; // [R3]

    // Fault sets only after a full deglitch window, clears at once
    if (!r.sup_sync.vm_under_level) begin
      nxt.uv_cnt = '0;
      nxt.uv_flt = 1'b0; // [R1]
    end else if (r.uv_cnt == DEG_LAST) begin
      nxt.uv_flt = 1'b1; // [R1]
    end else begin
      nxt.uv_cnt = r.uv_cnt + 11'h001;
    end
    if (!ov_raw) begin
      nxt.ov_cnt = '0;
      nxt.ov_flt = 1'b0; // [R2]
    end else if (r.ov_cnt == DEG_LAST) begin
      nxt.ov_flt = 1'b1; // [R2]
    end else begin
      nxt.ov_cnt = r.ov_cnt + 11'h001;
    end

    if (fault_clear_cmd || (status_read && clear_on_read_enable)) begin
      nxt.power_up_flag_n = 1'b1; // [R5]
    end

    case (r.mode)
      HBP_SLEEP: begin
        if (r.en_sync) begin
          nxt.mode = HBP_RUN;
        end
      end
      HBP_RUN: begin
        if (r.uv_flt || r.ov_flt) begin
          nxt.mode = HBP_FAULT;
        end
      end
      HBP_FAULT: begin
        if (!r.uv_flt && !r.ov_flt) begin
          nxt.mode = HBP_RUN; // [R1] [R2]
        end
      end
      default: begin
        nxt.mode = HBP_SLEEP;
      end
    endcase

    drive_ok = r.mode == HBP_RUN && !r.uv_flt && !r.ov_flt; // [R1] [R2]

    // ----------------------------------------
    // Per-bridge target and cross protection
    // ----------------------------------------
    for (int i = 0; i < `HBP_NUM_BRIDGES; i++) begin
      c = bridge_cfg[i];
      both = c.high_side_on && c.low_side_on; // [R10]
      if (c.bridge_pwm_select) begin
        on_p = gen_out[c.bridge_gen_select]; // [R13] [R14]
        // Enabled FET follows waveform; opposite only when active freewheel
        tgt_hs = !both && (c.high_side_on ? on_p : (c.low_side_on && c.freewheel_select && !on_p)); // [R15] [R17] [R22]
        tgt_ls = !both && (c.low_side_on ? on_p : (c.high_side_on && c.freewheel_select && !on_p)); // [R15] [R17] [R22]
      end else begin
        tgt_hs = c.high_side_on && !c.low_side_on; // [R9] [R19]
        tgt_ls = c.low_side_on && !c.high_side_on; // [R9] [R19]
      end
      tgt_hs = tgt_hs && drive_ok;
      tgt_ls = tgt_ls && drive_ok;

      if (r.dead[i].cnt != 12'h000) begin
        nxt.dead[i].cnt = r.dead[i].cnt - 12'h001;
      end
      // Gap only blocks the opposite FET, so passive PWM keeps full duty
      blk_hs = (r.dead[i].cnt != 12'h000 && !r.dead[i].from_hs) || r.gate[i].ls; // [R17]
      blk_ls = (r.dead[i].cnt != 12'h000 && r.dead[i].from_hs) || r.gate[i].hs; // [R17]
      nxt.gate[i].hs = tgt_hs && (r.gate[i].hs || !blk_hs);
      nxt.gate[i].ls = tgt_ls && (r.gate[i].ls || !blk_ls);
      if (r.gate[i].hs && !tgt_hs) begin
        nxt.dead[i].cnt = c.slew_select ? DEAD_FAST : DEAD_SLOW; // [R18]
        nxt.dead[i].from_hs = 1'b1;
      end else if (r.gate[i].ls && !tgt_ls) begin
        nxt.dead[i].cnt = c.slew_select ? DEAD_FAST : DEAD_SLOW; // [R18]
        nxt.dead[i].from_hs = 1'b0;
      end
    end

    // Sleep overrides everything but the input synchronisers
    if (!r.en_sync) begin
      nxt.mode = HBP_SLEEP; // [R6]
      nxt.uv_cnt = '0;
      nxt.ov_cnt = '0;
      nxt.uv_flt = 1'b0;
      nxt.ov_flt = 1'b0;
      nxt.power_up_flag_n = `HBP_FLAG_RST; // [R5] [R6]
      nxt.gate = '0; // [R6]
      nxt.dead = '0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // The low reset is the logic-supply power-on detector
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0; // [R4] [R5]
    end else if (ce) begin
      r <= nxt;
    end
  end

  assign gate_drive = r.gate;
  assign charge_pump_en = r.mode != HBP_SLEEP; // [R4] [R6]
  assign power_up_flag_n = r.power_up_flag_n;
  assign uv_fault = r.uv_flt;
  assign ov_fault = r.ov_flt;
  assign map4_on = gen_out[bridge_cfg[4].bridge_gen_select];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst || !ce);

  sequence s_ls_falls;
    $fell(r.gate[0].ls);
  endsequence

  sequence s_hs_held_off;
    !r.gate[0].hs [*8];
  endsequence

  sequence s_hs6_falls;
    $fell(r.gate[6].hs) && r.mode == HBP_RUN;
  endsequence

  sequence s_ls6_held_off;
    !r.gate[6].ls [*8];
  endsequence

  sequence s_uv_gone;
    $fell(uv_fault) && !ov_fault && r.en_sync;
  endsequence

  sequence s_ov_gone;
    $fell(ov_fault) && !uv_fault && r.en_sync;
  endsequence

  AST_UV_OFF: assert property (uv_fault |=> gate_drive == '0) // [R1]
    else $error("outputs on during under-voltage");
  AST_UV_DEGLITCH: assert property ($rose(uv_fault) |-> $past(r.uv_cnt) == 11'(DEG_CYC - 1)) // [R1]
    else $error("under-voltage flagged before deglitch window");
  AST_OV_OFF: assert property (ov_fault |=> gate_drive == '0) // [R2]
    else $error("outputs on during over-voltage");
  AST_OV_SEL: assert property ($rose(ov_fault) |-> $past(ov_raw, 1)) // [R3]
    else $error("over-voltage raised without selected comparator");
  AST_EN_LOW: assert property (!r.en_sync |=> gate_drive == '0 && !charge_pump_en && !power_up_flag_n) // [R6]
    else $error("sleep did not float outputs and reset");
  AST_FLAG_CLR: assert property (r.en_sync && (fault_clear_cmd || (status_read && clear_on_read_enable)) // [R5]
    |=> power_up_flag_n)
    else $error("power-up flag not set by clear");
  AST_BOTH_HIZ: assert property (bridge_cfg[2].high_side_on && bridge_cfg[2].low_side_on // [R10]
    |=> gate_drive[2] == '0)
    else $error("bridge driven with both side bits set");
  AST_DEAD_GAP: assert property (s_ls_falls |-> s_hs_held_off) // [R17] [R18]
    else $error("high side on inside cross gap");
  AST_NO_SHOOT: assert property (!(gate_drive[0].hs && gate_drive[0].ls)) // [R17]
    else $error("both FETs on");
  AST_PASSIVE: assert property (bridge_cfg[4].bridge_pwm_select && !bridge_cfg[4].freewheel_select // [R22]
    && bridge_cfg[4].high_side_on && !bridge_cfg[4].low_side_on |=> !gate_drive[4].ls)
    else $error("opposite FET on in passive freewheel");

  // ----------------------------------------
  // Bridge checks
  // ----------------------------------------
  AST_DIRECT_HS: assert property (!bridge_cfg[2].bridge_pwm_select && bridge_cfg[2].high_side_on // [R9]
    && !bridge_cfg[2].low_side_on && drive_ok && r.en_sync && !r.gate[2].ls
    && (r.dead[2].cnt == 12'h000 || r.dead[2].from_hs) |=> gate_drive[2] == 2'b10)
    else $error("direct high side not driven");
  AST_DIRECT_LS: assert property (!bridge_cfg[1].bridge_pwm_select && bridge_cfg[1].low_side_on // [R9] [R19]
    && !bridge_cfg[1].high_side_on && drive_ok && r.en_sync && !r.gate[1].hs
    && (r.dead[1].cnt == 12'h000 || !r.dead[1].from_hs) |=> gate_drive[1] == 2'b01)
    else $error("direct low side not driven");
  AST_DIRECT_OFF: assert property (!bridge_cfg[3].bridge_pwm_select && !bridge_cfg[3].high_side_on // [R9]
    && !bridge_cfg[3].low_side_on |=> gate_drive[3] == '0)
    else $error("direct bridge driven with no side bit");
  AST_MAP_FOLLOW: assert property (bridge_cfg[4].bridge_pwm_select // [R13] [R14] [R15]
    && bridge_cfg[4].high_side_on && !bridge_cfg[4].low_side_on && drive_ok && r.en_sync && !r.gate[4].ls
    && (r.dead[4].cnt == 12'h000 || r.dead[4].from_hs)
    |=> gate_drive[4].hs == $past(map4_on))
    else $error("PWM bridge not following its mapped generator");
  AST_FW_GAP: assert property (s_hs6_falls |-> s_ls6_held_off) // [R17] [R18]
    else $error("freewheel FET on inside cross gap");

  // ----------------------------------------
  // Supply, mode and clock-enable checks
  // ----------------------------------------
  AST_UV_RESUME: assert property (s_uv_gone |=> r.mode == HBP_RUN) // [R1]
    else $error("no resume after under-voltage");
  AST_OV_RESUME: assert property (s_ov_gone |=> r.mode == HBP_RUN) // [R2]
    else $error("no resume after over-voltage");
  AST_FAULT_MODE: assert property (r.en_sync && (uv_fault || ov_fault) |=> r.mode == HBP_FAULT) // [R1] [R2]
    else $error("supply fault did not stop driving");
  AST_WAKE_RUN: assert property ($rose(r.en_sync) |=> charge_pump_en) // [R6]
    else $error("pump not started after enable");
  // Own disable: the default one would mask exactly the frozen cycles
  AST_CE_HOLD: assert property (disable iff (!nrst) !ce |=> $stable(r))
    else $error("state moved while clock enable low");
endmodule : hbp_bridge_ctrl

// file: hdl/hbp_params.svh
`ifndef HBP_PARAMS_SVH
`define HBP_PARAMS_SVH

// ----------------------------------------
// Clock and array sizes
// ----------------------------------------
`define HBP_CLK_MHZ 100
`define HBP_NUM_BRIDGES 12
`define HBP_NUM_GENS 8

// ----------------------------------------
// Supply monitor timing
// ----------------------------------------
`define HBP_DEGLITCH_US 10
`define HBP_DEGLITCH_CYC (`HBP_DEGLITCH_US * `HBP_CLK_MHZ)

// ----------------------------------------
// Cross-protection gap per slew setting
// ----------------------------------------
`define HBP_DEAD_SLOW_US 28
`define HBP_DEAD_FAST_US 7
`define HBP_DEAD_SLOW_CYC (`HBP_DEAD_SLOW_US * `HBP_CLK_MHZ)
`define HBP_DEAD_FAST_CYC (`HBP_DEAD_FAST_US * `HBP_CLK_MHZ)

// ----------------------------------------
// PWM frequencies, duty scale, slot timing
// ----------------------------------------
`define HBP_FREQ0_HZ 80
`define HBP_FREQ1_HZ 100
`define HBP_FREQ2_HZ 200
`define HBP_FREQ3_HZ 2000
`define HBP_DUTY_FULL 255
`define HBP_SLOT_LAST 8'hFE
`define HBP_STEP_CYC(f) ((`HBP_CLK_MHZ * 1000000) / ((f) * `HBP_DUTY_FULL))

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HBP_FLAG_RST 1'b0

`endif

// file: hdl/hbp_pkg.sv
package hbp_pkg;
`include "hbp_params.svh"

  typedef enum logic [1:0] {
    HBP_SLEEP = 2'b00,
    HBP_RUN = 2'b01,
    HBP_FAULT = 2'b11
  } hbp_mode_t;

  typedef struct packed {
    logic bridge_pwm_select;
    logic high_side_on;
    logic low_side_on;
    logic freewheel_select;
    logic slew_select;
    logic [2:0] bridge_gen_select;
  } hbp_bridge_cfg_t;

  typedef struct packed {
    logic gen_stop;
    logic [1:0] gen_freq_code;
    logic [7:0] gen_duty_value;
  } hbp_gen_cfg_t;

  typedef struct packed {
    logic hs;
    logic ls;
  } hbp_gate_t;

  typedef struct packed {
    logic vm_under_level;
    logic vm_over_level_lo;
    logic vm_over_level_hi;
  } hbp_supply_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic from_hs;
  } hbp_dead_t;

  typedef struct packed {
    logic en_meta;
    logic en_sync;
    hbp_supply_t sup_meta;
    hbp_supply_t sup_sync;
    hbp_mode_t mode;
    logic [10:0] uv_cnt;
    logic [10:0] ov_cnt;
    logic uv_flt;
    logic ov_flt;
    logic power_up_flag_n;
    hbp_gate_t [`HBP_NUM_BRIDGES-1:0] gate;
    hbp_dead_t [`HBP_NUM_BRIDGES-1:0] dead;
  } hbp_top_st_t;

  typedef struct packed {
    logic [12:0] pre;
    logic [7:0] slot;
    logic out;
  } hbp_gen_st_t;

endpackage : hbp_pkg

// file: hdl/hbp_pwm_gen.sv
`include "hbp_params.svh"
module hbp_pwm_gen #(
  parameter logic [12:0] STEP0 = 13'h0001,
  parameter logic [12:0] STEP1 = 13'h0001,
  parameter logic [12:0] STEP2 = 13'h0001,
  parameter logic [12:0] STEP3 = 13'h0001
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  input wire hbp_pkg::hbp_gen_cfg_t cfg,
  output logic pwm_on
);
  import hbp_pkg::*;

  hbp_gen_st_t r;
  hbp_gen_st_t nxt;
  logic [12:0] step;

  always_comb begin
    nxt = r;
    case (cfg.gen_freq_code)
      2'h0: step = STEP0;
      2'h1: step = STEP1;
      2'h2: step = STEP2;
      default: step = STEP3;
    endcase
    if (!run) begin
      nxt = '0; // [R20]
    end else begin
      // Comparing with >= lets a shorter period take over mid-slot
      if (r.pre >= step - 13'h0001) begin // [R11] [R21]
        nxt.pre = '0;
        nxt.slot = (r.slot == `HBP_SLOT_LAST) ? 8'h00 : r.slot + 8'h01;
      end else begin
        nxt.pre = r.pre + 13'h0001;
      end
      // 255 slots: duty 0 never on, 255 always on
      nxt.out = r.slot < cfg.gen_duty_value; // [R12]
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else if (ce) begin
      r <= nxt;
    end
  end

  assign pwm_on = r.out;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst || !ce);

  AST_GEN_STOP: assert property (!run |=> !pwm_on) // [R20]
    else $error("stopped generator output not off");
  AST_GEN_FULL: assert property (run && $past(run) && cfg.gen_duty_value == 8'hFF |=> pwm_on) // [R12]
    else $error("full duty not permanently on");
  AST_GEN_ZERO: assert property (cfg.gen_duty_value == 8'h00 |=> !pwm_on) // [R12]
    else $error("zero duty output turned on");
endmodule : hbp_pwm_gen

// file: dv/hbp_host_model.sv
// ----
// Host side: control bits as the host writes them
// ----
module hbp_host_model #(
  parameter int WAKE_CYC = 15000
) (
  input wire logic clk,
  output logic en,
  output logic overvolt_level_sel,
  output logic clear_on_read_enable,
  output logic status_read,
  output logic fault_clear_cmd,
  output hbp_pkg::hbp_bridge_cfg_t [11:0] bridge_cfg,
  output hbp_pkg::hbp_gen_cfg_t [7:0] gen_cfg
);
  timeunit 1ns;
  timeprecision 100ps;
  import hbp_pkg::*;

  initial begin
    en = 1'h0;
    overvolt_level_sel = 1'h0;
    clear_on_read_enable = 1'h0;
    status_read = 1'h0;
    fault_clear_cmd = 1'h0;
    bridge_cfg = '0;
    gen_cfg = '0;
  end

  task automatic set_bridge(input int i, input hbp_bridge_cfg_t v);
    @(negedge clk);
    bridge_cfg[i] = v;
  endtask : set_bridge

  task automatic set_gen(input int i, input hbp_gen_cfg_t v);
    @(negedge clk);
    gen_cfg[i] = v;
  endtask : set_gen

  task automatic set_ctrl(input logic ovsel, input logic cor);
    @(negedge clk);
    overvolt_level_sel = ovsel;
    clear_on_read_enable = cor;
  endtask : set_ctrl

  // One-cycle strobe: clear command or status read
  task automatic pulse(input logic clr);
    @(negedge clk);
    fault_clear_cmd = clr;
    status_read = ~clr;
    @(negedge clk);
    fault_clear_cmd = 1'h0;
    status_read = 1'h0;
  endtask : pulse

  // Outputs not trusted before the pump has settled
  task automatic wake();
    @(negedge clk);
    en = 1'h1;
    repeat (WAKE_CYC) @(negedge clk);
  endtask : wake

  task automatic sleep();
    @(negedge clk);
    en = 1'h0;
  endtask : sleep
endmodule : hbp_host_model

// file: dv/hbp_bridge_ctrl_tb.sv
module hbp_bridge_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import hbp_pkg::*;
  // Short slot steps keep a PWM period near 1000-1800 cycles
  localparam int STEP [4] = '{4, 5, 6, 7};
  localparam int WAKE = 50;
  logic ref_clk;
  logic nrst;
  logic ce;
  logic en;
  logic ovsel;
  logic cor;
  logic rd;
  logic clr;
  hbp_supply_t supply;
  hbp_bridge_cfg_t [11:0] bcfg;
  hbp_gen_cfg_t [7:0] gcfg;
  hbp_gate_t [11:0] gate_drive;
  logic charge_pump_en;
  logic power_up_flag_n;
  logic uv_fault;
  logic ov_fault;
  int err_total;
  int n_checks;

  hbp_bridge_ctrl #(.P_STEP0(STEP[0]), .P_STEP1(STEP[1]), .P_STEP2(STEP[2]), .P_STEP3(STEP[3])) hbp_bridge_ctrl_i (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .en(en), .supply(supply), .overvolt_level_sel(ovsel),
    .clear_on_read_enable(cor), .status_read(rd), .fault_clear_cmd(clr), .bridge_cfg(bcfg),
    .gen_cfg(gcfg), .gate_drive(gate_drive), .charge_pump_en(charge_pump_en),
    .power_up_flag_n(power_up_flag_n), .uv_fault(uv_fault), .ov_fault(ov_fault)
  );
  hbp_host_model #(.WAKE_CYC(WAKE)) hbp_host_model_i (
    .clk(ref_clk), .en(en), .overvolt_level_sel(ovsel), .clear_on_read_enable(cor),
    .status_read(rd), .fault_clear_cmd(clr), .bridge_cfg(bcfg), .gen_cfg(gcfg)
  );

  // ----
  // Compare helpers
  // ----
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk_bit

  task automatic chk_gate(input hbp_gate_t got, input hbp_gate_t exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %b", $time, msg, got);
    end
  endtask : chk_gate

  task automatic chk_cnt(input int got, input int exp, input string msg);
    n_checks++;
    if (got != exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, msg, got, exp);
    end
  endtask : chk_cnt

  // Gap from high-side off to low-side on, bounded waits
  task automatic gap(input int b, input int exp);
    int n;
    n = 0;
    repeat (5000) if (gate_drive[b].hs !== 1'h1) @(negedge ref_clk);
    repeat (5000) if (gate_drive[b].hs !== 1'h0) @(negedge ref_clk);
    repeat (4000) if (gate_drive[b].ls !== 1'h1) begin
      @(negedge ref_clk);
      n++;
    end
    chk_cnt(n, exp, "cross gap");
  endtask : gap

  // Restart two generators, count gate highs over one full period
  task automatic run_pair(input int c, input logic [7:0] d5, input logic [7:0] d6);
    int h4;
    int l4;
    int h5;
    h4 = 0;
    l4 = 0;
    h5 = 0;
    hbp_host_model_i.set_gen(5, '{1'h1, c[1:0], d5});
    hbp_host_model_i.set_gen(6, '{1'h1, c[1:0], d6});
    hbp_host_model_i.set_gen(5, '{1'h0, c[1:0], d5});
    hbp_host_model_i.set_gen(6, '{1'h0, c[1:0], d6});
    repeat (4) @(negedge ref_clk);
    repeat (255 * STEP[c]) begin
      @(negedge ref_clk);
      h4 += int'(gate_drive[4].hs === 1'h1);
      l4 += int'(gate_drive[4].ls === 1'h1);
      h5 += int'(gate_drive[5].hs === 1'h1);
    end
    chk_cnt(h4, int'(d5) * STEP[c], "duty bridge 4");
    chk_cnt(h5, int'(d6) * STEP[c], "duty bridge 5");
    chk_cnt(l4, 0, "passive low side");
  endtask : run_pair

  // ----
  // Scenarios
  // ----
  task automatic test_flag();
    chk_bit(charge_pump_en, 1'h1, "pump after wake");
    chk_bit(power_up_flag_n, 1'h0, "flag after power-up");
    hbp_host_model_i.pulse(1'h0);
    @(negedge ref_clk);
    chk_bit(power_up_flag_n, 1'h0, "plain read");
    hbp_host_model_i.set_ctrl(1'h0, 1'h1);
    hbp_host_model_i.pulse(1'h0);
    @(negedge ref_clk);
    chk_bit(power_up_flag_n, 1'h1, "read with clear-on-read");
  endtask : test_flag

  task automatic test_direct();
    hbp_gate_t exp_g [4];
    exp_g = '{2'b10, 2'b01, 2'b00, 2'b00};
    hbp_host_model_i.set_gen(0, '{1'h0, 2'h3, 8'h80});
    hbp_host_model_i.set_bridge(0, '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 3'h0});
    hbp_host_model_i.set_bridge(1, '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 3'h0});
    hbp_host_model_i.set_bridge(2, '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 3'h0});
    hbp_host_model_i.set_bridge(3, '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 3'h0});
    repeat (3) @(negedge ref_clk);
    for (int b = 0; b < 4; b++) chk_gate(gate_drive[b], exp_g[b], "direct gate");
    hbp_host_model_i.set_bridge(2, '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 3'h0});
    repeat (3) @(negedge ref_clk);
    chk_gate(gate_drive[2], 2'b10, "both-set released");
    // Clock enable low must freeze the bridges, then let them follow again
    ce = 1'h0;
    hbp_host_model_i.set_bridge(3, '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 3'h0});
    repeat (3) @(negedge ref_clk);
    chk_gate(gate_drive[3], 2'b00, "frozen by clock enable");
    ce = 1'h1;
    repeat (3) @(negedge ref_clk);
    chk_gate(gate_drive[3], 2'b10, "clock enable released");
    hbp_host_model_i.set_bridge(0, '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 3'h0});
    gap(0, 2801);
  endtask : test_direct

  task automatic test_supply();
    supply = 3'b100;
    repeat (900) @(negedge ref_clk);
    chk_bit(uv_fault, 1'h0, "short undervoltage");
    repeat (200) @(negedge ref_clk);
    chk_bit(uv_fault, 1'h1, "undervoltage");
    chk_gate(gate_drive[2], 2'b00, "undervoltage off");
    supply = '0;
    repeat (8) @(negedge ref_clk);
    chk_gate(gate_drive[2], 2'b10, "undervoltage resume");
    for (int s = 0; s < 2; s++) begin
      hbp_host_model_i.set_ctrl(s[0], 1'h1);
      supply = s ? 3'b010 : 3'b001;
      repeat (1100) @(negedge ref_clk);
      chk_bit(ov_fault, 1'h0, "unselected level");
      supply = s ? 3'b001 : 3'b010;
      repeat (1100) @(negedge ref_clk);
      chk_bit(ov_fault, 1'h1, "overvoltage");
      chk_gate(gate_drive[2], 2'b00, "overvoltage off");
      supply = '0;
      repeat (8) @(negedge ref_clk);
      chk_gate(gate_drive[2], 2'b10, "overvoltage resume");
    end
  endtask : test_supply

  task automatic test_pwm();
    hbp_host_model_i.set_bridge(4, '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h5});
    hbp_host_model_i.set_bridge(5, '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h6});
    for (int c = 0; c < 4; c++) run_pair(c, 8'h33, 8'hC8);
    run_pair(3, 8'h00, 8'hFF);
    hbp_host_model_i.set_gen(5, '{1'h1, 2'h3, 8'hFF});
    repeat (4) @(negedge ref_clk);
    repeat (255 * STEP[3]) begin
      @(negedge ref_clk);
      chk_bit(gate_drive[4].hs, 1'h0, "stopped generator");
    end
    hbp_host_model_i.set_gen(7, '{1'h0, 2'h3, 8'h80});
    hbp_host_model_i.set_bridge(6, '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 3'h7});
    gap(6, 701);
  endtask : test_pwm

  task automatic test_sleep();
    hbp_host_model_i.sleep();
    repeat (4) @(negedge ref_clk);
    chk_gate(gate_drive[2], 2'b00, "sleep gate");
    chk_bit(charge_pump_en, 1'h0, "sleep pump");
    chk_bit(power_up_flag_n, 1'h0, "sleep flag");
    hbp_host_model_i.wake();
    chk_gate(gate_drive[2], 2'b10, "wake gate");
    hbp_host_model_i.pulse(1'h1);
    @(negedge ref_clk);
    chk_bit(power_up_flag_n, 1'h1, "clear command");
    nrst = 1'h0;
    #1;
    chk_gate(gate_drive[2], 2'b00, "power-on reset gate");
    chk_bit(charge_pump_en, 1'h0, "power-on reset pump");
    chk_bit(power_up_flag_n, 1'h0, "power-on reset flag");
    @(negedge ref_clk);
    nrst = 1'h1;
  endtask : test_sleep

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    nrst = 1'h0;
    ce = 1'h1;
    supply = '0;
    err_total = 0;
    n_checks = 0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'h1;
    hbp_host_model_i.wake();
    test_flag();
    test_direct();
    test_supply();
    test_pwm();
    test_sleep();
    summarize();
  end

  initial begin
    #600000;
    err_total++;
    summarize();
  end
endmodule : hbp_bridge_ctrl_tb
